// ### inc/ssc_consts.svh
// How it works
// - Receive-valid strap sampled in reset: high gives PHY-like role, low MAC-like.
// - Receive data 3 strap: high enables port 2 negotiation, low disables it.
// - Negotiation off: receive data 2 strap high forces 100, low forces 10.
// - Receive data 1 strap picks full or half duplex, forced or fallback.
// - Receive data 0 strap high forces flow control, low follows negotiation.
// - Reduced-pin variant: transmit data 3 strap gates the reference clock output.
// - MII variant: transmit clock driven in PHY-like and serial modes, input otherwise.
// - MII variant: receive clock driven in PHY-like role, input in MAC-like role.
// - PHY-like role: host link indicator high means no link, enter bypass.
// - Power-down input low powers the chip down, dropping all configuration.
// - Strap pins are pulled-up inputs during reset; receive valid and receive data pins are outputs after release,
//   except reduced-pin receive data 3, driven only with the transmit data 3 strap high.
// - Serial data-out strap: high selects 25 MHz, low 50 MHz core clock.
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

`define SSC_ADDR_W 8
`define SSC_REG_STRAP 8'h00
`define SSC_REG_CTRL 8'h04
`define SSC_REG_STATUS 8'h08

`define SSC_CTRL_BYPASS 0
`define SSC_CTRL_SERIAL_NETWORK_MODE 1
`define SSC_CTRL_RST 2'h0

`define SSC_STAT_BYPASS 3
`define SSC_STAT_SPEED 4
`define SSC_STAT_DUPLEX 5
`define SSC_STAT_FLOWCTL 6
`define SSC_STAT_VALID 7

`define SSC_STRAP_RST 7'h7f
`define SSC_ZERO32 32'h0000_0000

`endif

// ### inc/ssc_pkg.sv
package ssc_pkg;

	typedef enum logic [2:0] {
		ST_SAMPLE = 3'h1,
		ST_RUN = 3'h2,
		ST_PDN = 3'h4
	} ssc_state_t;

	typedef struct packed {
		logic clk_sel_25m;
		logic refclk_en;
		logic force_fc;
		logic full_dpx;
		logic speed_100;
		logic autoneg;
		logic phy_role;
	} ssc_strap_t;

	typedef struct packed {
		ssc_state_t state;
		logic [1:0] ctrl;
		logic [31:0] rdata;
		logic p2_speed_100;
		logic p2_full_dpx;
		logic p2_flowctl;
		logic bypass;
		logic clk_sel_50m;
		logic [3:0] rxd;
		logic rxdv;
		logic crs;
		logic crs_in;
		logic txc;
		logic rxc;
		logic txc_in;
		logic rxc_in;
		logic sdo;
	} ssc_top_t;

	typedef struct packed {
		ssc_strap_t shadow;
		ssc_strap_t held;
	} ssc_latch_t;

endpackage

// ### inc/ssc_latch_if.sv
interface ssc_latch_if;
	logic sample;
	logic commit;
	logic clear;
	ssc_pkg::ssc_strap_t pins;
	ssc_pkg::ssc_strap_t held;

	modport ctl (
		output sample,
		output commit,
		output clear,
		output pins,
		input held
	);

	modport lat (
		input sample,
		input commit,
		input clear,
		input pins,
		output held
	);
endinterface

// ### verilog/ssc_strap_latch.sv
`include "ssc_consts.svh"

module ssc_strap_latch (
	// Clock
	input wire logic core_clk,
	// Control and data
	ssc_latch_if.lat lk
);

	localparam logic [6:0] STRAP_RST = `SSC_STRAP_RST;

	ssc_pkg::ssc_latch_t q;
	ssc_pkg::ssc_latch_t d;
	logic [6:0] shadow_nx;
	logic [6:0] held_nx;

	// Per strap bit shadow and hold
	genvar i;
	generate
		for (i = 0; i < 7; i++) begin : g_bit
			assign shadow_nx[i] = lk.sample ? lk.pins[i] : q.shadow[i];
			assign held_nx[i] = lk.clear ? STRAP_RST[i] : (lk.commit ? q.shadow[i] : q.held[i]);
		end
	endgenerate

	always_comb begin
		d = q;
		d.shadow = shadow_nx;
		d.held = held_nx;
	end

	always_ff @(posedge core_clk) begin
		q <= d;
	end

	assign lk.held = q.held;

endmodule

// ### verilog/ssc_strap_capture.sv
// Chosen here: strobed register access and the placing of the registers.
`include "ssc_consts.svh"

module ssc_strap_capture #(
	parameter int RMII_VARIANT = 0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Power-down input
	input wire logic chip_powerdown_n,
	// Port 3 receive valid
	input wire logic port3_rx_valid_pin_i,
	output logic port3_rx_valid_pin_o,
	output logic port3_rx_valid_pin_oe,
	// Port 3 receive data
	input wire logic [3:0] port3_rx_data_pin_i,
	output logic [3:0] port3_rx_data_pin_o,
	output logic [3:0] port3_rx_data_pin_oe,
	// Port 3 transmit data 3 and error
	input wire logic port3_tx_data3_pin,
	input wire logic port3_tx_error_pin,
	// Port 3 transmit clock
	input wire logic port3_tx_clock_pin_i,
	output logic port3_tx_clock_pin_o,
	output logic port3_tx_clock_pin_oe,
	// Port 3 receive clock
	input wire logic port3_rx_clock_pin_i,
	output logic port3_rx_clock_pin_o,
	output logic port3_rx_clock_pin_oe,
	// Port 3 carrier sense
	input wire logic port3_carrier_sense_pin_i,
	output logic port3_carrier_sense_pin_o,
	output logic port3_carrier_sense_pin_oe,
	// Serial data out
	input wire logic serial_data_out_pin_i,
	output logic serial_data_out_pin_o,
	output logic serial_data_out_pin_oe,
	// Core side of port 3
	input wire logic mii_rx_valid,
	input wire logic [3:0] mii_rx_data,
	input wire logic mii_crs,
	input wire logic int_tx_clk,
	input wire logic int_rx_clk,
	input wire logic int_refclk,
	input wire logic spi_q,
	input wire logic spi_q_en,
	output logic port3_crs_in,
	output logic port3_tx_clk_in,
	output logic port3_rx_clk_in,
	// Port 2 negotiation results
	input wire logic an_done,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic an_pause,
	// Decoded configuration
	output logic config_valid,
	output logic port3_phy_role,
	output logic port2_autoneg_strap,
	output logic port2_speed_100,
	output logic port2_full_duplex,
	output logic port2_flowctl_en,
	output logic port2_force_flowctl_strap,
	output logic refclk_out_enable_strap,
	output logic core_clk_sel_50m,
	output logic bypass_p1_p2,
	output logic chip_powered_down
);

	generate
		if (RMII_VARIANT < 0 || RMII_VARIANT > 1) begin : g_chk
			$error("RMII_VARIANT must be 0 or 1");
		end
	endgenerate

	localparam logic RMII = (RMII_VARIANT == 1);
	localparam ssc_pkg::ssc_top_t TOP_RST = '{state: ssc_pkg::ST_SAMPLE, default: '0};

	ssc_pkg::ssc_top_t q;
	ssc_pkg::ssc_top_t d;
	ssc_pkg::ssc_strap_t cfg;
	ssc_pkg::ssc_strap_t pins_now;
	logic run;
	logic pdn;
	logic sample_win;
	logic commit;
	logic serial_network_mode;
	logic host_no_link;
	logic drive_rxd3;

	ssc_latch_if lk ();

	ssc_strap_latch u_latch (
		.core_clk(core_clk),
		.lk(lk)
	);

	// Strap pin gathering
	always_comb begin
		pins_now = '0;
		pins_now.phy_role = port3_rx_valid_pin_i;
		pins_now.autoneg = port3_rx_data_pin_i[3];
		pins_now.speed_100 = port3_rx_data_pin_i[2];
		pins_now.full_dpx = port3_rx_data_pin_i[1];
		pins_now.force_fc = port3_rx_data_pin_i[0];
		pins_now.refclk_en = RMII & port3_tx_data3_pin;
		pins_now.clk_sel_25m = serial_data_out_pin_i;
	end

	// Phase decode
	assign run = (q.state == ssc_pkg::ST_RUN);
	assign pdn = ~chip_powerdown_n;
	assign sample_win = reset | (q.state != ssc_pkg::ST_RUN);
	assign commit = ~reset & ~pdn & (q.state == ssc_pkg::ST_SAMPLE);
	assign cfg = lk.held;
	assign serial_network_mode = q.ctrl[`SSC_CTRL_SERIAL_NETWORK_MODE];
	assign host_no_link = cfg.phy_role & port3_tx_error_pin;
	assign drive_rxd3 = ~RMII | cfg.refclk_en;

	// Latch control
	assign lk.sample = sample_win;
	assign lk.commit = commit;
	assign lk.clear = reset | pdn;
	assign lk.pins = pins_now;

	// Next state
	always_comb begin
		d = q;
		d.rdata = `SSC_ZERO32;
		case (q.state)
			ssc_pkg::ST_SAMPLE: begin
				if (pdn) begin
					d.state = ssc_pkg::ST_PDN;
				end else begin
					d.state = ssc_pkg::ST_RUN;
				end
			end
			ssc_pkg::ST_RUN: begin
				if (pdn) begin
					d.state = ssc_pkg::ST_PDN;
				end
			end
			ssc_pkg::ST_PDN: begin
				if (!pdn) begin
					d.state = ssc_pkg::ST_SAMPLE;
				end
			end
			default: begin
				d.state = ssc_pkg::ST_SAMPLE;
			end
		endcase

		// Register writes
		if (reg_wr && reg_addr == `SSC_REG_CTRL) begin
			d.ctrl = reg_wdata[1:0];
		end
		if (pdn) begin
			d.ctrl = `SSC_CTRL_RST;
		end

		// Register reads
		if (reg_rd) begin
			case (reg_addr)
				`SSC_REG_STRAP: begin
					d.rdata = {25'h000_0000, cfg};
				end
				`SSC_REG_CTRL: begin
					d.rdata = {30'h0000_0000, q.ctrl};
				end
				`SSC_REG_STATUS: begin
					d.rdata = `SSC_ZERO32;
					d.rdata[2:0] = q.state;
					d.rdata[`SSC_STAT_BYPASS] = q.bypass;
					d.rdata[`SSC_STAT_SPEED] = q.p2_speed_100;
					d.rdata[`SSC_STAT_DUPLEX] = q.p2_full_dpx;
					d.rdata[`SSC_STAT_FLOWCTL] = q.p2_flowctl;
					d.rdata[`SSC_STAT_VALID] = run;
				end
				default: begin
					d.rdata = `SSC_ZERO32;
				end
			endcase
		end

		// Port 2 effective settings
		d.p2_speed_100 = 1'b0;
		d.p2_full_dpx = 1'b0;
		d.p2_flowctl = 1'b0;
		if (run) begin
			if (cfg.autoneg) begin
				d.p2_speed_100 = an_speed_100;
				d.p2_full_dpx = an_done ? an_full_duplex : cfg.full_dpx;
			end else begin
				d.p2_speed_100 = cfg.speed_100;
				d.p2_full_dpx = cfg.full_dpx;
			end
			d.p2_flowctl = cfg.force_fc | (cfg.autoneg & an_done & an_pause);
		end

		// Bypass between ports 1 and 2
		d.bypass = run & (host_no_link | q.ctrl[`SSC_CTRL_BYPASS]);
		d.clk_sel_50m = ~cfg.clk_sel_25m;

		// Pin output data
		d.rxdv = mii_rx_valid;
		d.rxd = mii_rx_data;
		if (RMII) begin
			d.rxd[3] = int_refclk;
		end
		d.crs = mii_crs;
		d.txc = int_tx_clk;
		d.rxc = int_rx_clk;
		d.sdo = spi_q;

		// Inputs toward the core
		d.crs_in = run & ~cfg.phy_role & port3_carrier_sense_pin_i;
		d.txc_in = port3_tx_clock_pin_i;
		d.rxc_in = port3_rx_clock_pin_i;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	// Pin drive, outputs enabled only in the run state
	assign port3_rx_valid_pin_o = q.rxdv;
	assign port3_rx_valid_pin_oe = run;
	assign port3_rx_data_pin_o = q.rxd;
	assign port3_rx_data_pin_oe = {run & drive_rxd3, {3{run}}};
	assign port3_tx_clock_pin_o = q.txc;
	assign port3_tx_clock_pin_oe = run & ~RMII & (cfg.phy_role | serial_network_mode);
	assign port3_rx_clock_pin_o = q.rxc;
	assign port3_rx_clock_pin_oe = run & ~RMII & cfg.phy_role;
	assign port3_carrier_sense_pin_o = q.crs;
	assign port3_carrier_sense_pin_oe = run & ~RMII & cfg.phy_role;
	assign serial_data_out_pin_o = q.sdo;
	assign serial_data_out_pin_oe = run & spi_q_en;

	// Core side and configuration
	assign reg_rdata = q.rdata;
	assign port3_crs_in = q.crs_in;
	assign port3_tx_clk_in = q.txc_in;
	assign port3_rx_clk_in = q.rxc_in;
	assign config_valid = run;
	assign port3_phy_role = cfg.phy_role;
	assign port2_autoneg_strap = cfg.autoneg;
	assign port2_speed_100 = q.p2_speed_100;
	assign port2_full_duplex = q.p2_full_dpx;
	assign port2_flowctl_en = q.p2_flowctl;
	assign port2_force_flowctl_strap = cfg.force_fc;
	assign refclk_out_enable_strap = cfg.refclk_en;
	assign core_clk_sel_50m = q.clk_sel_50m;
	assign bypass_p1_p2 = q.bypass;
	assign chip_powered_down = (q.state == ssc_pkg::ST_PDN);

endmodule

// ### testbench/ssc_strap_capture_properties.sv
module ssc_strap_capture_properties #(
	parameter int RMII_VARIANT = 0
) (
	// Clock, reset, pin inputs and receive data output enables
	input wire logic core_clk, reset, chip_powerdown_n, port3_rx_valid_pin_i, port3_tx_error_pin,
	input wire logic [3:0] port3_rx_data_pin_i, port3_rx_data_pin_oe,
	// Device outputs
	input wire logic port3_rx_valid_pin_oe, port3_tx_clock_pin_oe, port3_rx_clock_pin_oe, config_valid,
	input wire logic port3_phy_role, port2_autoneg_strap, port2_force_flowctl_strap, port2_flowctl_en,
	input wire logic bypass_p1_p2, chip_powered_down
);
	localparam bit mii_mode = RMII_VARIANT == 0;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_latch;
		$fell(reset) |=> {port3_phy_role, port2_autoneg_strap, port2_force_flowctl_strap} ==
			$past({port3_rx_valid_pin_i, port3_rx_data_pin_i[3], port3_rx_data_pin_i[0]}, 2);
	endproperty
	a_latch: assert property (p_latch) else $error("Strap bits not latched");
	property p_hold;
		config_valid && $past(config_valid) |-> $stable({port3_phy_role, port2_autoneg_strap, port2_force_flowctl_strap});
	endproperty
	a_hold: assert property (p_hold) else $error("Latched strap changed");
	property p_oe_off;
		!config_valid |-> !port3_rx_valid_pin_oe && port3_rx_data_pin_oe == 4'h0 && !port3_tx_clock_pin_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("Pin driven before run");
	property p_rxc;
		port3_rx_clock_pin_oe == (config_valid && port3_phy_role && mii_mode);
	endproperty
	a_rxc: assert property (p_rxc) else $error("Receive clock drive wrong");
	property p_txc;
		config_valid && port3_phy_role && mii_mode |-> port3_tx_clock_pin_oe;
	endproperty
	a_txc: assert property (p_txc) else $error("Transmit clock not driven");
	property p_bypass;
		config_valid && port3_phy_role && port3_tx_error_pin && chip_powerdown_n |=> bypass_p1_p2;
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypass not entered");
	property p_flow;
		config_valid && port2_force_flowctl_strap && chip_powerdown_n |=> port2_flowctl_en;
	endproperty
	a_flow: assert property (p_flow) else $error("Flow control not forced");
	property p_pdn;
		!chip_powerdown_n |=> chip_powered_down && !config_valid;
	endproperty
	a_pdn: assert property (p_pdn) else $error("Power-down not entered");
endmodule

bind ssc_strap_capture ssc_strap_capture_properties #(.RMII_VARIANT(RMII_VARIANT)) u_props (
	.core_clk(core_clk),
	.reset(reset),
	.chip_powerdown_n(chip_powerdown_n),
	.port3_rx_valid_pin_i(port3_rx_valid_pin_i),
	.port3_tx_error_pin(port3_tx_error_pin),
	.port3_rx_data_pin_i(port3_rx_data_pin_i),
	.port3_rx_data_pin_oe(port3_rx_data_pin_oe),
	.port3_rx_valid_pin_oe(port3_rx_valid_pin_oe),
	.port3_tx_clock_pin_oe(port3_tx_clock_pin_oe),
	.port3_rx_clock_pin_oe(port3_rx_clock_pin_oe),
	.config_valid(config_valid),
	.port3_phy_role(port3_phy_role),
	.port2_autoneg_strap(port2_autoneg_strap),
	.port2_force_flowctl_strap(port2_force_flowctl_strap),
	.port2_flowctl_en(port2_flowctl_en),
	.bypass_p1_p2(bypass_p1_p2),
	.chip_powered_down(chip_powered_down)
);

// ### testbench/ssc_host_model.sv
module ssc_host_model (
	// Clock and strap levels, register order
	input wire logic core_clk,
	input wire logic [6:0] strap,
	// Device drive and pins: crs, rxc, txc, sdo, txd3, rxd[3:0], rxdv
	input wire logic [9:0] dev_o,
	input wire logic [9:0] dev_oe,
	output logic [9:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic rx_act = 1'b0;
	logic [9:0] far;
	// Powered PHY clocks port 3 where the device does not
	always @(posedge core_clk) begin
		hclk <= ~hclk;
		rx_act <= rx_act ^ hclk;
	end
	// Carrier from ORed activity, both clocks from hclk, pulled strap levels elsewhere
	assign far = {hclk | rx_act, hclk, hclk, strap[6:5], strap[1], strap[2], strap[3], strap[4], strap[0]};
	assign pin = (dev_oe & dev_o) | (~dev_oe & far);
endmodule

// ### testbench/tb_switch_strap_config_capture.sv
`include "ssc_consts.svh"

module tb_switch_strap_config_capture;
	timeunit 1ns;
	timeprecision 1ns;
	// Bench driven
	logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, chip_powerdown_n = 1'b1;
	logic port3_tx_error_pin = 1'b0, an_done = 1'b0, an_speed_100 = 1'b0, an_full_duplex = 1'b0, an_pause = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	// Pins
	wire logic port3_rx_valid_pin_i, port3_tx_data3_pin, port3_tx_clock_pin_i, port3_rx_clock_pin_i;
	wire logic port3_carrier_sense_pin_i, serial_data_out_pin_i;
	wire logic [3:0] port3_rx_data_pin_i;
	logic port3_rx_valid_pin_o, port3_rx_valid_pin_oe, port3_tx_clock_pin_o, port3_tx_clock_pin_oe;
	logic port3_rx_clock_pin_o, port3_rx_clock_pin_oe, port3_carrier_sense_pin_o, port3_carrier_sense_pin_oe;
	logic serial_data_out_pin_o, serial_data_out_pin_oe;
	logic [3:0] port3_rx_data_pin_o, port3_rx_data_pin_oe, mii_rx_data;
	// Core side and configuration
	logic mii_rx_valid, mii_crs, int_tx_clk, int_rx_clk, int_refclk, spi_q, spi_q_en;
	logic port3_crs_in, port3_tx_clk_in, port3_rx_clk_in, config_valid, port3_phy_role, port2_autoneg_strap;
	logic port2_speed_100, port2_full_duplex, port2_flowctl_en, port2_force_flowctl_strap, refclk_out_enable_strap;
	logic core_clk_sel_50m, bypass_p1_p2, chip_powered_down;
	// Bench state
	logic [6:0] strap = 7'h7f;
	logic [15:0] cyc = 16'h0000;
	logic [15:0] cyc_m1;
	logic [2:0] far_in;
	int miscompares = 0;
	int tests_run = 0;
	logic [6:0] tab [2] = '{7'h75, 7'h2a};
	logic [2:0] p2x [2] = '{3'h5, 3'h6};

	assign {mii_rx_valid, mii_crs, spi_q, spi_q_en} = cyc[7:4];
	assign mii_rx_data = cyc[3:0];
	assign cyc_m1 = cyc - 16'h0001;
	assign {int_tx_clk, int_rx_clk, int_refclk} = {3{cyc[0]}};

	ssc_strap_capture #(.RMII_VARIANT(0)) dut (.*);
	ssc_host_model host (
		.core_clk(core_clk),
		.strap(strap),
		.dev_o({port3_carrier_sense_pin_o, port3_rx_clock_pin_o, port3_tx_clock_pin_o, serial_data_out_pin_o,
			1'b0, port3_rx_data_pin_o, port3_rx_valid_pin_o}),
		.dev_oe({port3_carrier_sense_pin_oe, port3_rx_clock_pin_oe, port3_tx_clock_pin_oe, serial_data_out_pin_oe,
			1'b0, port3_rx_data_pin_oe, port3_rx_valid_pin_oe}),
		.pin({port3_carrier_sense_pin_i, port3_rx_clock_pin_i, port3_tx_clock_pin_i, serial_data_out_pin_i,
			port3_tx_data3_pin, port3_rx_data_pin_i, port3_rx_valid_pin_i})
	);

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc <= cyc + 16'h0001;
		if (cyc == 16'h07d0) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One write or read cycle, read data checked under mask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1;
		if (!w) chk(reg_rdata & m, d);
	endtask

	task automatic settle();
		for (int n = 0; n < 8 && config_valid !== 1'b1; n++) @(posedge core_clk);
		#1 chk(config_valid, 32'h0000_0001);
	endtask

	task automatic boot(input logic [6:0] s);
		@(posedge core_clk);
		strap <= s;
		reset <= 1'b1;
		port3_tx_error_pin <= 1'b0;
		an_done <= ~s[1];
		an_speed_100 <= ~s[2];
		an_full_duplex <= ~s[3];
		an_pause <= 1'b1;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		settle();
	endtask

	initial begin
		for (int i = 0; i < 2; i++) begin
			boot(tab[i]);
			bus(1'b0, `SSC_REG_STRAP, {25'h0, tab[i] & 7'h5f}, 32'h0000_007f);
			chk({core_clk_sel_50m, refclk_out_enable_strap}, {!tab[i][6], 1'b0});
			chk({port2_speed_100, port2_full_duplex, port2_flowctl_en}, p2x[i]);
			chk({port3_tx_clock_pin_oe, port3_rx_clock_pin_oe, port3_carrier_sense_pin_oe}, {3{tab[i][0]}});
			chk({port3_rx_valid_pin_o, port3_rx_data_pin_o}, {cyc_m1[7], cyc_m1[3:0]});
			chk({port3_carrier_sense_pin_o, serial_data_out_pin_o, serial_data_out_pin_oe}, {cyc_m1[6:5], cyc[4]});
			chk({port3_tx_clock_pin_o, port3_rx_clock_pin_o}, {2{cyc_m1[0]}});
			far_in = {port3_carrier_sense_pin_i & !tab[i][0], port3_tx_clock_pin_i, port3_rx_clock_pin_i};
			@(posedge core_clk);
			#1 chk({port3_crs_in, port3_tx_clk_in, port3_rx_clk_in}, far_in);
			@(posedge core_clk);
			port3_tx_error_pin <= 1'b1;
			strap <= ~tab[i];
			repeat (3) @(posedge core_clk);
			#1 chk(bypass_p1_p2, tab[i][0]);
			bus(1'b0, `SSC_REG_STATUS, {24'h0, 1'b1, p2x[i][0], p2x[i][1], p2x[i][2], tab[i][0], 3'h2},
				32'hffff_ffff);
			bus(1'b0, `SSC_REG_STRAP, {25'h0, tab[i] & 7'h5f}, 32'h0000_007f);
		end
		bus(1'b1, `SSC_REG_CTRL, 32'h0000_0002, 32'hffff_ffff);
		repeat (2) @(posedge core_clk);
		#1 chk(port3_tx_clock_pin_oe, 32'h0000_0001);
		bus(1'b0, `SSC_REG_CTRL, 32'h0000_0002, 32'hffff_ffff);
		bus(1'b0, 8'h10, 32'h0000_0000, 32'hffff_ffff);
		@(posedge core_clk);
		chip_powerdown_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk({chip_powered_down, config_valid}, 2'h2);
		@(posedge core_clk);
		chip_powerdown_n <= 1'b1;
		settle();
		bus(1'b0, `SSC_REG_CTRL, 32'h0000_0000, 32'hffff_ffff);
		bus(1'b0, `SSC_REG_STRAP, {25'h0, ~tab[1] & 7'h5f}, 32'h0000_007f);
		finish_test();
	end
endmodule
